// ---- shared/sld_pkg.sv ----
`default_nettype none
package sld_pkg;

	// Word geometry
	localparam int WORD_BITS = 24;
	localparam int SEL_LO_POS = 0;
	localparam int SEL_HI_POS = 1;

	// Latch select codes, {latch_select_hi, latch_select_lo}
	localparam logic [1:0] SEL_CONFIG = 2'h0;
	localparam logic [1:0] SEL_REF = 2'h1;
	localparam logic [1:0] SEL_FEEDBACK = 2'h2;
	localparam logic [1:0] SEL_TEST = 2'h3;

	// Main configuration word fields
	localparam int CFG_PRESCALER_POS = 22;
	localparam int CFG_CP_GAIN_POS = 10;
	localparam int CFG_PFD_POL_POS = 8;
	localparam int CFG_MUX_POS = 5;
	localparam int CFG_CNT_RST_POS = 4;
	localparam int CFG_CORE_CUR_POS = 2;

	// Feedback divider word fields
	localparam int FB_DIV2_SEL_POS = 23;
	localparam int FB_DIV2_POS = 22;
	localparam int FB_CP_GAIN_POS = 21;
	localparam int FB_MAIN_POS = 8;
	localparam int FB_RSVD_POS = 7;
	localparam int FB_SWALLOW_POS = 2;

	// Reference divider word fields
	localparam int REF_BAND_DIV_POS = 20;
	localparam int REF_TEST_POS = 19;
	localparam int REF_LOCK_PREC_POS = 18;
	localparam int REF_BACKLASH_POS = 16;
	localparam int REF_DIV_POS = 2;

	// Field widths
	localparam int SWALLOW_BITS = 5;
	localparam int MAIN_BITS = 13;
	localparam int REF_BITS = 14;

	// Lock run lengths
	localparam logic [2:0] LOCK_RUN_LONG = 3'h5;
	localparam logic [2:0] LOCK_RUN_SHORT = 3'h3;

	// Reset values
	localparam logic [23:0] WORD_RESET = 24'h000000;
	localparam logic [2:0] MUX_SEL_RESET = 3'h0;

	// Multiplexed output select codes
	localparam logic [2:0] MUX_TRISTATE = 3'h0;
	localparam logic [2:0] MUX_DLOCK = 3'h1;
	localparam logic [2:0] MUX_NDIV = 3'h2;
	localparam logic [2:0] MUX_DVDD = 3'h3;
	localparam logic [2:0] MUX_RDIV = 3'h4;
	localparam logic [2:0] MUX_ALOCK = 3'h5;
	localparam logic [2:0] MUX_SDO = 3'h6;
	localparam logic [2:0] MUX_DGND = 3'h7;

	typedef struct packed {
		logic sclk;
		logic sdata;
		logic strobe;
	} sld_serial_type;

	typedef struct packed {
		logic [1:0] prescaler_sel;
		logic       pfd_polarity_sel;
		logic [2:0] outmux_sel;
		logic       counter_reset;
		logic [1:0] core_current_sel;
		logic       cp_gain;
		logic       div2_enable;
		logic       div2_to_prescaler;
		logic [1:0] backlash_width;
		logic       lock_precision_sel;
		logic       factory_test_sel;
		logic [1:0] band_logic_div;
	} sld_ctrl_type;

endpackage
`default_nettype wire

// ---- logic/sld_divider.sv ----
`default_nettype none
// Programmable counter; one pulse every 'ratio' ticks
module sld_divider
	import sld_pkg::*;
#(
	parameter int WIDTH = 14
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             srst,
	// Control
	input  wire logic             hold,
	input  wire logic             tick,
	input  wire logic [WIDTH-1:0] ratio,
	// Output
	output logic                  pulse
);

	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic             pulse;
	} sld_div_state_type;

	sld_div_state_type state;
	sld_div_state_type next_state;

	always_comb begin
		next_state = state;
		next_state.pulse = 1'b0;
		if (hold) begin
			next_state.count = '0;
		end else if (tick) begin
			// Count 1..ratio; ratio of 0 or 1 yields a pulse per tick
			if (state.count + WIDTH'(1) >= ratio) begin
				next_state.count = '0;
				next_state.pulse = 1'b1;
			end else begin
				next_state.count = state.count + WIDTH'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign pulse = state.pulse;

endmodule
`default_nettype wire

// ---- logic/sld_latch_decode.sv ----
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Polarity bit 1 positive, 0 negative
// - Three-bit select routes signal to output pin
// - Counter reset bit holds all counters
// - Select (1,0) loads feedback divider word
// - Select (0,1) loads reference divider word
// - Swallow count is five bits, 0..31
// - Main feedback count thirteen bits, 3..8191
// - Total ratio is modulus times main plus swallow
// - Gain bit follows latest write, either word
// - Feedback bit 22 enables output halving
// - Feedback bit 23 feeds halved signal to prescaler
// - Reference divider fourteen bits, 1..16383
// - Reference bits 16-17 pick backlash width
// - Lock after five or three good cycles
// - Test bit zero ignores test latch
// - Band logic clock from reference, optional divider
// - Select (0,0) loads main configuration word
// - Shift 24 bits, commit on strobe rise
//////////////////////////////////////////////////////////////////////////////
module sld_latch_decode
	import sld_pkg::*;
(
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               srst,
	// Serial programming pins
	input  wire sld_serial_type     serial_in,
	// Synthesizer timing inputs, pin level
	input  wire logic               ref_in,
	input  wire logic               vco_in,
	input  wire logic               phase_good,
	input  wire logic               analog_lock,
	// Decoded controls
	output sld_ctrl_type            ctrl,
	output logic [SWALLOW_BITS-1:0] swallow_count,
	output logic [MAIN_BITS-1:0]    main_feedback_count,
	output logic [REF_BITS-1:0]     ref_divide_value,
	output logic [MAIN_BITS+5:0]    total_ratio,
	// Divider and lock outputs
	output logic                    ref_div_pulse,
	output logic                    fb_div_pulse,
	output logic                    band_clk_pulse,
	output logic                    lock_detect,
	output logic                    output_clk,
	output logic                    multiplexed_output_pin,
	output logic                    multiplexed_output_oe
);

	typedef struct packed {
		logic [2:0]           sclk_sync;
		logic [1:0]           sdata_sync;
		logic [2:0]           strobe_sync;
		logic [2:0]           ref_sync;
		logic [2:0]           vco_sync;
		logic [1:0]           good_sync;
		logic [1:0]           alock_sync;
		logic [WORD_BITS-1:0] shift;
		logic [WORD_BITS-1:0] config_word;
		logic [WORD_BITS-1:0] feedback_word;
		logic [WORD_BITS-1:0] reference_word;
		logic [WORD_BITS-1:0] test_word;
		logic                 cp_gain;
		logic [2:0]           good_run;
		logic                 locked;
		logic                 half_clk;
		logic [3:0]           band_count;
		logic                 band_pulse;
		logic                 mux_out;
	} sld_state_type;

	sld_state_type state;
	sld_state_type next_state;

	logic sclk_rise;
	logic strobe_rise;
	logic ref_rise;
	logic vco_rise;
	logic presc_tick;
	logic counters_hold;
	logic [3:0] band_ratio;
	logic [MAIN_BITS+5:0] modulus;

	// Prescaler modulus from the two-bit code
	function automatic logic [MAIN_BITS+5:0] prescaler_modulus(input logic [1:0] code);
		case (code)
			2'h0: prescaler_modulus = (MAIN_BITS+6)'(8);
			2'h1: prescaler_modulus = (MAIN_BITS+6)'(16);
			default: prescaler_modulus = (MAIN_BITS+6)'(32);
		endcase
	endfunction

	// Band clock division from the two-bit code
	function automatic logic [3:0] band_divide(input logic [1:0] code);
		case (code)
			2'h0: band_divide = 4'h1;
			2'h1: band_divide = 4'h2;
			2'h2: band_divide = 4'h4;
			default: band_divide = 4'h8;
		endcase
	endfunction

	// Rise from the synchronised stage; third stage is history, and on the VCO also drives output_clk
	function automatic logic rose(input logic [2:0] hist);
		rose = hist[1] & ~hist[2];
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// Field decode

	always_comb begin
		ctrl.prescaler_sel = state.config_word[CFG_PRESCALER_POS +: 2];
		ctrl.pfd_polarity_sel = state.config_word[CFG_PFD_POL_POS];
		ctrl.outmux_sel = state.config_word[CFG_MUX_POS +: 3];
		ctrl.counter_reset = state.config_word[CFG_CNT_RST_POS];
		ctrl.core_current_sel = state.config_word[CFG_CORE_CUR_POS +: 2];
		ctrl.cp_gain = state.cp_gain;
		ctrl.div2_enable = state.feedback_word[FB_DIV2_POS];
		ctrl.div2_to_prescaler = state.feedback_word[FB_DIV2_SEL_POS];
		ctrl.backlash_width = state.reference_word[REF_BACKLASH_POS +: 2];
		ctrl.lock_precision_sel = state.reference_word[REF_LOCK_PREC_POS];
		ctrl.factory_test_sel = state.reference_word[REF_TEST_POS];
		ctrl.band_logic_div = state.reference_word[REF_BAND_DIV_POS +: 2];
	end

	assign swallow_count = state.feedback_word[FB_SWALLOW_POS +: SWALLOW_BITS];
	assign main_feedback_count = state.feedback_word[FB_MAIN_POS +: MAIN_BITS];
	assign ref_divide_value = state.reference_word[REF_DIV_POS +: REF_BITS];

	assign modulus = prescaler_modulus(ctrl.prescaler_sel);
	assign total_ratio = (MAIN_BITS+6)'(modulus * (MAIN_BITS+6)'(main_feedback_count))
		+ (MAIN_BITS+6)'(swallow_count);

	//////////////////////////////////////////////////////////////////////////
	// Edge detection on synchronised pins

	assign sclk_rise = rose(state.sclk_sync);
	assign strobe_rise = rose(state.strobe_sync);
	assign ref_rise = rose(state.ref_sync);
	assign vco_rise = rose(state.vco_sync);
	assign counters_hold = ctrl.counter_reset;
	// Halved signal rises on every other VCO rise
	assign presc_tick = ctrl.div2_to_prescaler ? (vco_rise & ~state.half_clk) : vco_rise;
	assign band_ratio = band_divide(ctrl.band_logic_div);

	//////////////////////////////////////////////////////////////////////////
	// Dividers

	sld_divider #(
		.WIDTH (REF_BITS)
	) u_ref_div (
		.clk   (clk),
		.srst  (srst),
		.hold  (counters_hold),
		.tick  (ref_rise),
		.ratio (ref_divide_value),
		.pulse (ref_div_pulse)
	);

	// Feedback ratio counted directly; zero main count is out of range
	sld_divider #(
		.WIDTH (MAIN_BITS+6)
	) u_fb_div (
		.clk   (clk),
		.srst  (srst),
		.hold  (counters_hold),
		.tick  (presc_tick),
		.ratio (total_ratio),
		.pulse (fb_div_pulse)
	);

	//////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_state = state;
		// Two flip-flops before use, third for edge history and, on the VCO, for output_clk
		next_state.sclk_sync = {state.sclk_sync[1:0], serial_in.sclk};
		next_state.sdata_sync = {state.sdata_sync[0], serial_in.sdata};
		next_state.strobe_sync = {state.strobe_sync[1:0], serial_in.strobe};
		next_state.ref_sync = {state.ref_sync[1:0], ref_in};
		next_state.vco_sync = {state.vco_sync[1:0], vco_in};
		next_state.good_sync = {state.good_sync[0], phase_good};
		next_state.alock_sync = {state.alock_sync[0], analog_lock};
		next_state.band_pulse = 1'b0;

		// Data sampled on clock rise, first bit ends at the top
		if (sclk_rise) begin
			next_state.shift = {state.shift[WORD_BITS-2:0], state.sdata_sync[1]};
		end

		// Commit on strobe rise; latch chosen by the two low bits
		if (strobe_rise) begin
			case (state.shift[SEL_HI_POS:SEL_LO_POS])
				SEL_CONFIG: begin
					next_state.config_word = state.shift;
					next_state.cp_gain = state.shift[CFG_CP_GAIN_POS];
				end
				SEL_FEEDBACK: begin
					next_state.feedback_word = state.shift;
					next_state.cp_gain = state.shift[FB_CP_GAIN_POS];
				end
				SEL_REF: begin
					next_state.reference_word = state.shift;
				end
				default: begin
					// Kept but never used, whether the test bit is set or clear
					next_state.test_word = state.shift;
				end
			endcase
		end

		// Output halving toggles per VCO rise
		if (counters_hold) begin
			next_state.half_clk = 1'b0;
		end else if (vco_rise) begin
			next_state.half_clk = ~state.half_clk;
		end

		// Band logic clock from reference output, optionally divided
		if (counters_hold) begin
			next_state.band_count = 4'h0;
		end else if (ref_div_pulse) begin
			if (state.band_count + 4'h1 >= band_ratio) begin
				next_state.band_count = 4'h0;
				next_state.band_pulse = 1'b1;
			end else begin
				next_state.band_count = state.band_count + 4'h1;
			end
		end

		// Lock needs a run of good reference cycles; a bad one drops it
		if (counters_hold) begin
			next_state.good_run = 3'h0;
			next_state.locked = 1'b0;
		end else if (ref_div_pulse) begin
			if (!state.good_sync[1]) begin
				next_state.good_run = 3'h0;
				next_state.locked = 1'b0;
			end else if (!state.locked) begin
				next_state.good_run = state.good_run + 3'h1;
				if (state.good_run + 3'h1
					>= (ctrl.lock_precision_sel ? LOCK_RUN_LONG : LOCK_RUN_SHORT)) begin
					next_state.locked = 1'b1;
				end
			end
		end

		// Multiplexed output routing
		case (ctrl.outmux_sel)
			MUX_DLOCK: next_state.mux_out = state.locked;
			MUX_NDIV: next_state.mux_out = fb_div_pulse;
			MUX_DVDD: next_state.mux_out = 1'b1;
			MUX_RDIV: next_state.mux_out = ref_div_pulse;
			MUX_ALOCK: next_state.mux_out = state.alock_sync[1];
			MUX_SDO: next_state.mux_out = state.shift[WORD_BITS-1];
			MUX_DGND: next_state.mux_out = 1'b0;
			default: next_state.mux_out = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state <= '0;
			state.config_word <= WORD_RESET;
			state.feedback_word <= WORD_RESET;
			state.reference_word <= WORD_RESET;
		end else begin
			state <= next_state;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Outputs

	assign lock_detect = state.locked;
	assign band_clk_pulse = state.band_pulse;
	assign output_clk = ctrl.div2_enable ? state.half_clk : state.vco_sync[2];
	assign multiplexed_output_pin = state.mux_out;
	// Three-state code floats the pin
	assign multiplexed_output_oe = (ctrl.outmux_sel != MUX_TRISTATE);

endmodule
`default_nettype wire

// ---- dv/sld_latch_decode_assertions.sv ----
`default_nettype none
module sld_latch_decode_assertions
	import sld_pkg::*;
(
	// Clock and reset
	input wire logic                    clk,
	input wire logic                    srst,
	// Observed ports
	input wire logic                    phase_good,
	input wire sld_ctrl_type            ctrl,
	input wire logic [SWALLOW_BITS-1:0] swallow_count,
	input wire logic [MAIN_BITS-1:0]    main_feedback_count,
	input wire logic [MAIN_BITS+5:0]    total_ratio,
	input wire logic                    ref_div_pulse,
	input wire logic                    fb_div_pulse,
	input wire logic                    lock_detect,
	input wire logic                    multiplexed_output_pin,
	input wire logic                    multiplexed_output_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	// Good samples seen at reference pulses; saturates so it never wraps to zero
	logic [3:0]  run;
	logic [3:0]  next_run;
	logic [18:0] modulus;
	always_comb begin
		next_run = run;
		if (ctrl.counter_reset || (ref_div_pulse && !phase_good)) begin
			next_run = 4'h0;
		end else if (ref_div_pulse && run != 4'hf) begin
			next_run = run + 4'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			run <= 4'h0;
		end else begin
			run <= next_run;
		end
	end
	assign modulus = (ctrl.prescaler_sel == 2'h0) ? 19'h8 :
		(ctrl.prescaler_sel == 2'h1) ? 19'h10 : 19'h20;

	//////////////////////////////////////////////////////////////////////////////
	chk_oe_select: assert property (multiplexed_output_oe == (ctrl.outmux_sel != MUX_TRISTATE))
		else $error("output enable does not follow select");
	chk_mux_high: assert property (ctrl.outmux_sel == MUX_DVDD && $stable(ctrl.outmux_sel)
		|-> multiplexed_output_pin) else $error("mux pin not high");
	chk_mux_low: assert property (ctrl.outmux_sel == MUX_DGND && $stable(ctrl.outmux_sel)
		|-> !multiplexed_output_pin) else $error("mux pin not low");
	chk_ratio_sum: assert property (total_ratio == modulus * 19'(main_feedback_count)
		+ 19'(swallow_count)) else $error("total ratio wrong");
	chk_cnt_hold: assert property (ctrl.counter_reset [*3]
		|-> !ref_div_pulse && !fb_div_pulse && !lock_detect) else $error("counters run in reset");
	chk_ref_single: assert property (ref_div_pulse |=> !ref_div_pulse)
		else $error("reference pulse too long");
	chk_fb_single: assert property (fb_div_pulse |=> !fb_div_pulse)
		else $error("feedback pulse too long");
	chk_lock_run: assert property ($rose(lock_detect)
		|-> run >= (ctrl.lock_precision_sel ? 4'h5 : 4'h3)) else $error("lock too early");
	chk_lock_drop: assert property (ref_div_pulse && !phase_good |-> ##[1:2] !lock_detect)
		else $error("lock kept after bad sample");
endmodule

bind sld_latch_decode sld_latch_decode_assertions u_sld_latch_decode_assertions (.clk, .srst,
	.phase_good, .ctrl, .swallow_count, .main_feedback_count, .total_ratio, .ref_div_pulse,
	.fb_div_pulse, .lock_detect, .multiplexed_output_pin, .multiplexed_output_oe);
`default_nettype wire

// ---- dv/sld_host_model.sv ----
`default_nettype none
module sld_host_model
	import sld_pkg::*;
(
	// Clock
	input wire logic           clk,
	// Serial pins
	output var sld_serial_type serial
);
	timeunit 1ns;
	timeprecision 1ps;
	initial serial = 3'h0;
	// Half is clocks per phase; one is the fastest the synchroniser sees
	task automatic send(input logic [23:0] w, input int half);
		for (int i = 23; i >= 0; i--) begin
			serial.sdata = w[i];
			serial.sclk = 1'b0;
			repeat (half) @(negedge clk);
			serial.sclk = 1'b1;
			repeat (half) @(negedge clk);
		end
		serial.sclk = 1'b0;
		repeat (half) @(negedge clk);
		serial.strobe = 1'b1;
		repeat (half) @(negedge clk);
		serial.strobe = 1'b0;
		// Released data shows the inverse, never a held value
		serial.sdata = ~w[0];
		repeat (half) @(negedge clk);
	endtask
endmodule
`default_nettype wire

// ---- dv/synth_latch_decode_dividers_tb.sv ----
`default_nettype none
module synth_latch_decode_dividers_tb
	import sld_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [1:0] CORE_CUR = 2'h1; // A valid core current code
	logic clk, srst, ref_in, vco_in, phase_good, analog_lock;
	logic [1:0] tick;
	sld_serial_type serial;
	sld_ctrl_type ctrl;
	logic [SWALLOW_BITS-1:0] swallow_count;
	logic [MAIN_BITS-1:0] main_feedback_count;
	logic [REF_BITS-1:0] ref_divide_value;
	logic [MAIN_BITS+5:0] total_ratio;
	logic ref_div_pulse, fb_div_pulse, band_clk_pulse, lock_detect, output_clk, mux_pin, mux_oe;
	logic [49:0] obs, last_exp;
	logic [49:0] exp_q[$];
	logic [23:0] cfg_w, fb_w, rf_w;
	logic gain;
	integer seed;
	int failures, total_checks, cycles;

	sld_host_model u_sld_host_model (.clk(clk), .serial(serial));
	sld_latch_decode u_sld_latch_decode (.clk(clk), .srst(srst), .serial_in(serial),
		.ref_in(ref_in), .vco_in(vco_in), .phase_good(phase_good), .analog_lock(analog_lock),
		.ctrl(ctrl), .swallow_count(swallow_count), .main_feedback_count(main_feedback_count),
		.ref_divide_value(ref_divide_value), .total_ratio(total_ratio),
		.ref_div_pulse(ref_div_pulse), .fb_div_pulse(fb_div_pulse),
		.band_clk_pulse(band_clk_pulse), .lock_detect(lock_detect), .output_clk(output_clk),
		.multiplexed_output_pin(mux_pin), .multiplexed_output_oe(mux_oe));
	assign obs = {ctrl, swallow_count, main_feedback_count, ref_divide_value};

	//////////////////////////////////////////////////////////////////////////////
	function automatic logic [23:0] cfgw(logic [1:0] p, logic g, logic pol, logic [2:0] m);
		return {p, 11'h0, g, 1'b0, pol, m, 1'b0, CORE_CUR, SEL_CONFIG};
	endfunction
	function automatic logic [23:0] fbw(logic s, logic d, logic g, logic [12:0] b, logic [4:0] a);
		return {s, d, g, b, 1'b0, a, SEL_FEEDBACK};
	endfunction
	function automatic logic [23:0] refw(logic [1:0] bs, logic lp, logic [1:0] ab, logic [13:0] r);
		return {2'h0, bs, 1'b0, lp, ab, r, SEL_REF};
	endfunction
	function automatic logic [49:0] snap_exp();
		return {cfg_w[23:22], cfg_w[8], cfg_w[7:5], cfg_w[4], cfg_w[3:2], gain,
			fb_w[22], fb_w[23], rf_w[17:16], rf_w[18], rf_w[19], rf_w[21:20],
			fb_w[6:2], fb_w[20:8], rf_w[15:2]};
	endfunction
	function automatic logic [23:0] legal(logic [23:0] w);
		logic [12:0] b;
		logic [13:0] r;
		b = (w[20:8] < 13'h3) ? 13'h3 : w[20:8];
		r = (w[15:2] < 14'h2) ? 14'h2 : w[15:2];
		if (w[1] == 1'b1) begin
			return fbw(w[23], w[22], w[21], b, w[6:2]);
		end
		if (w[0] == 1'b1) begin
			return refw(w[21:20], w[18], w[17:16], r);
		end
		return cfgw(w[23:22], w[10], w[8], w[7:5]);
	endfunction

	task automatic check_val(input logic [49:0] got, input logic [49:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic check_bit(input logic got, input logic exp);
		check_val({49'h0, got}, {49'h0, exp});
	endtask
	task automatic put(input logic [23:0] w, input int half);
		logic [49:0] e;
		case (w[1:0])
			SEL_CONFIG: begin
				cfg_w = w;
				gain = w[10];
			end
			SEL_REF: rf_w = w;
			SEL_FEEDBACK: begin
				fb_w = w;
				gain = w[21];
			end
			default: ;
		endcase
		e = snap_exp();
		if (e !== last_exp) exp_q.push_back(e);
		last_exp = e;
		u_sld_host_model.send(w, half);
	endtask
	// Phase error changes after a pulse ends, so the synchronised copy settles first
	task automatic set_good(input logic v);
		@(posedge ref_div_pulse);
		@(negedge ref_div_pulse);
		@(negedge clk);
		phase_good = v;
	endtask
	task automatic lock_step(input int n, input logic v);
		repeat (n) @(posedge ref_div_pulse);
		repeat (3) @(negedge clk);
		check_bit(lock_detect, v);
	endtask
	task automatic report(input string name);
		$display("test done: %s", name);
	endtask
	task automatic pin_is(input logic v);
		repeat (4) @(negedge clk);
		check_bit(mux_pin, v);
	endtask
	// Reference pulses counted between two band clock pulses
	task automatic band_step(input int n);
		int k;
		k = 0;
		@(posedge band_clk_pulse);
		do begin
			@(negedge clk);
			if (ref_div_pulse === 1'b1) k++;
		end while (band_clk_pulse !== 1'b1 || k == 0);
		check_val(50'(k), 50'(n));
	endtask
	// Output clock rises in 32 cycles; the bench oscillator rises every 4
	task automatic clk_rises(input int n);
		int k;
		logic p;
		k = 0;
		@(negedge clk);
		p = output_clk;
		repeat (32) begin
			@(negedge clk);
			if (output_clk === 1'b1 && p === 1'b0) k++;
			p = output_clk;
		end
		check_val(50'(k), 50'(n));
	endtask
	task automatic conclude();
		$display("checks %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	//////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial tick = 2'h0;
	always @(negedge clk) begin
		tick <= tick + 2'h1;
		ref_in <= tick[1];
		vco_in <= tick[1] ^ tick[0];
	end
	initial cycles = 0;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			conclude();
		end
	end
	initial begin
		logic [49:0] prev;
		@(negedge srst);
		prev = obs;
		forever begin
			@(negedge clk);
			if (obs !== prev) begin
				if (exp_q.size() == 0) check_val(obs, prev);
				else check_val(obs, exp_q.pop_front());
				prev = obs;
			end
		end
	end

	initial begin
		srst = 1'b1;
		phase_good = 1'b1;
		analog_lock = 1'b0;
		seed = 31;
		{cfg_w, fb_w, rf_w, gain} = '0;
		last_exp = '0;
		failures = 0;
		total_checks = 0;
		repeat (8) @(negedge clk);
		srst = 1'b0;
		put(refw(2'h0, 1'b1, 2'h2, 14'h2), 2);
		for (int m = 0; m < 8; m++) begin
			put(cfgw(m[1:0], m[0], ~m[0], m[2:0]), 2);
		end
		put(fbw(1'b1, 1'b1, 1'b1, 13'h3, 5'h0), 2);
		report("power-up order and codes");
		clk_rises(4);
		put(cfgw(2'h1, 1'b0, 1'b1, MUX_DVDD), 4);
		put(fbw(1'b0, 1'b0, 1'b1, 13'h1fff, 5'h1f), 4);
		put(cfgw(2'h1, 1'b0, 1'b1, MUX_DVDD), 2);
		report("shared gain bit");
		clk_rises(8);
		put(refw(2'h3, 1'b0, 2'h1, 14'h3fff), 2);
		put(refw(2'h1, 1'b0, 2'h3, 14'h1), 2);
		put(24'h5a5a5b, 2);
		report("reference limits and test latch");
		put(cfgw(2'h1, 1'b0, 1'b1, MUX_DVDD) | 24'h000010, 2);
		check_bit(lock_detect, 1'b0);
		put(cfgw(2'h1, 1'b0, 1'b1, MUX_DVDD), 2);
		report("counter reset");
		put(refw(2'h2, 1'b1, 2'h0, 14'h2), 2);
		repeat (100) @(negedge clk);
		check_bit(lock_detect, 1'b1);
		band_step(4);
		set_good(1'b0);
		set_good(1'b1);
		lock_step(4, 1'b0);
		lock_step(2, 1'b1);
		put(refw(2'h2, 1'b0, 2'h0, 14'h2), 2);
		set_good(1'b0);
		set_good(1'b1);
		lock_step(2, 1'b0);
		lock_step(2, 1'b1);
		report("lock precision");
		put(cfgw(2'h2, 1'b0, 1'b1, MUX_SDO), 2);
		pin_is(1'b1);
		put(cfgw(2'h1, 1'b0, 1'b1, MUX_DLOCK), 2);
		pin_is(1'b1);
		analog_lock = 1'b1;
		put(cfgw(2'h1, 1'b0, 1'b1, MUX_ALOCK), 2);
		pin_is(1'b1);
		analog_lock = 1'b0;
		pin_is(1'b0);
		put(cfgw(2'h1, 1'b0, 1'b1, MUX_TRISTATE), 2);
		check_bit(mux_oe, 1'b0);
		report("output routing");
		for (int i = 0; i < 12; i++) begin
			analog_lock = 1'($random(seed));
			put(legal(24'($random(seed))), 2 + 2 * (i % 2));
		end
		repeat (20) @(negedge clk);
		check_val(obs, last_exp);
		report("random words");
		conclude();
	end
endmodule
`default_nettype wire
